/* hdl/pidsup_top.sv */
// Purpose: supervisory logic around the drive's process pid loop
// Assumes: APB slave, one clock, frequencies in 0.01 Hz, feedback in percent
// Notes: pid arithmetic, s-curve, jump and energy saving live elsewhere
// Function
// RQ1: fault response, loss held for loss time: stop, fault contact, fault code.
// RQ2: sleep enabled: stop after pid output below sleep frequency for sleep delay.
// RQ3: leave sleep only after reference above wake frequency for wake delay; code also leaves sleep when sleep is disabled or on loss fault.
// RQ4: sleep select 0 off, 1 by settings, 2 by digital input.
// RQ5: sleep timer runs below sleep frequency; at delay decelerate and sleep.
// RQ6: in sleep pid keeps running; on wake restart and ramp to reference.
// RQ7: same target and feedback source: reject setting, raise conflict alarm.
// RQ8: displayed feedback scaled by display gain and display bias.
// RQ9: pid target clamped between upper and lower limits in percent.
// RQ10: gain select 0 set one, 1 set two, 2 by input, 3 reserved.
// RQ11: by-input selection uses set two while function-54 input active.
// RQ12: set two holds own gain, integral and differential time, bounded ranges.
// RQ13: maximum feedback 1 to 10000 is the value for 100 percent target.
// RQ14: display decimal places selectable zero to four.
// RQ15: unit selector 0 to 23, zero meaning percent.
// RQ16: during disconnection warning output fallback frequency, restore after.
// RQ17: direction lock 0 both, 1 forward, 2 reverse; locked runs ignored.
// RQ18: carrier 0 variable, 1 is 1.5 kHz, 2 to 16 in kHz.
// RQ19: sensorless vector mode refuses carrier settings below 4 kHz.
// RQ20: installer limits carrier by motor cable length.
// RQ21: warning response, loss held for loss time: warning code, keep running.
// RQ22: loss time 0.0 to 10.0 s, loss level 0 to 100 percent.
// RQ23: each qualification timer restarts when its condition drops early.
`timescale 1ns/1ps
module pidsup_top (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] pid_out_freq,
   input wire logic [15:0] pid_ref_freq,
   input wire logic [6:0] fb_pct,
   input wire logic [1:0] tgt_src,
   input wire logic [1:0] fb_src,
   input wire logic [6:0] tgt_pct_in,
   input wire logic sleep_di,
   input wire logic [5:0] gain_di_fn,
   input wire logic gain_di,
   input wire logic run_fwd,
   input wire logic run_rev,
   input wire logic motor_stopped,
   input wire logic sensorless_vector_mode,
   output logic run_cmd,
   output logic dir_rev,
   output logic fault_contact,
   output logic [2:0] disp_code,
   output logic [15:0] freq_cmd,
   output logic [6:0] tgt_pct,
   output logic [15:0] fb_disp,
   output pidsup_pkg::pidsup_gain_t gain_act,
   output logic [4:0] carrier_khz,
   output logic carrier_var,
   output logic carrier_half
);
   import pidsup_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // configuration registers
   logic [1:0] loss_mode_ff;
   logic [6:0] loss_lvl_ff;
   logic [6:0] loss_time_ff;
   logic [15:0] slp_freq_ff;
   logic [11:0] slp_time_ff;
   logic [15:0] wake_freq_ff;
   logic [11:0] wake_time_ff;
   logic [1:0] slp_sel_ff;
   logic [1:0] gsel_ff;
   logic [1:0] dir_lock_ff;
   logic [4:0] carrier_ff;
   logic [6:0] tgt_hi_ff;
   logic [6:0] tgt_lo_ff;
   logic [15:0] disp_bias_ff;
   logic [15:0] disp_gain_ff;
   logic [2:0] dec_ff;
   logic [4:0] unit_ff;
   pidsup_gain_t gain1_ff;
   pidsup_gain_t gain2_ff;
   logic [13:0] maxfb_ff;
   logic [8:0] fallbk_ff;
   logic [5:0] di2_fn_ff;

   // status and timing
   pidsup_state_t state_ff, nxt_state;
   logic [23:0] tick_cnt_ff;
   logic tick;
   logic [6:0] loss_cnt_ff;
   logic [11:0] slp_cnt_ff;
   logic [11:0] wake_cnt_ff;
   logic loss_flag_ff;
   logic conflict_ff;
   logic cfg_rej_ff;
   logic run_cmd_ff;
   logic dir_rev_ff;

   ////////////////////////////////////////////////////////////////////
   // apb decode
   wire apb_wr = psel & penable & pwrite;
   wire apb_rd_sel = psel & ~pwrite;
   wire a_loss = paddr == OFS_LOSS;
   wire a_sleep = paddr == OFS_SLEEP;
   wire a_wake = paddr == OFS_WAKE;
   wire a_mode = paddr == OFS_MODE;
   wire a_tgt = paddr == OFS_TGT;
   wire a_disp = paddr == OFS_DISP;
   wire a_gain2 = paddr == OFS_GAIN2;
   wire a_maxfb = paddr == OFS_MAXFB;
   wire a_fallbk = paddr == OFS_FALLBK;
   wire a_status = paddr == OFS_STATUS;
   wire a_di2 = paddr == OFS_DI2;
   wire a_gain2b = paddr == OFS_GAIN2B;
   wire a_hit = a_loss | a_sleep | a_wake | a_mode | a_tgt | a_disp | a_gain2 |
      a_maxfb | a_fallbk | a_status | a_di2 | a_gain2b;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~a_hit;

   // write legality checks, out-of-range writes leave the field unchanged
   wire loss_ok = pwdata[1:0] != 2'h3 && pwdata[14:8] <= PCT_MAX
      && pwdata[22:16] <= LOSS_TMAX; // see RQ22
   wire slp_ok = pwdata[15:0] <= FREQ_MAX && pwdata[27:16] <= SLEEP_TMAX;
   wire car_ok = pwdata[12:8] <= CAR_MAX
      && !(sensorless_vector_mode && pwdata[12:8] < CAR_SLV_MIN); // see RQ19
   wire mode_ok = pwdata[1:0] != 2'h3 && pwdata[3:2] != 2'h3
      && pwdata[5:4] != 2'h3 && car_ok; // see RQ4 // see RQ10 // see RQ17
   wire tgt_ok = pwdata[6:0] <= PCT_MAX && pwdata[14:8] <= PCT_MAX
      && pwdata[14:8] <= pwdata[6:0]; // see RQ9
   wire disp_ok = $signed(pwdata[15:0]) >= -16'sd9999 && $signed(pwdata[15:0]) <= 16'sd9999
      && pwdata[31:16] <= 32'd10000; // see RQ8
   wire g2_ok = pwdata[9:0] <= GAIN_PMAX && pwdata[25:16] <= GAIN_IMAX; // see RQ12
   wire g2b_ok = pwdata[9:0] <= GAIN_DMAX && pwdata[18:16] <= DEC_MAX
      && pwdata[28:24] <= UNIT_MAX; // see RQ14 // see RQ15
   wire maxfb_ok = pwdata[13:0] >= MAXFB_MIN && pwdata[13:0] <= MAXFB_MAX; // see RQ13
   wire fb_ok = pwdata[8:0] <= FALLBK_MAX;

   // configuration write, loss field group in this process
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         loss_mode_ff <= LOSS_OFF;
         loss_lvl_ff <= 7'h00;
         loss_time_ff <= 7'h00;
      end else if (apb_wr && a_loss && loss_ok) begin
         loss_mode_ff <= pwdata[1:0];
         loss_lvl_ff <= pwdata[14:8];
         loss_time_ff <= pwdata[22:16];
      end
   end

   // sleep and wake settings
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         slp_freq_ff <= 16'h0000;
         slp_time_ff <= 12'h000;
         wake_freq_ff <= 16'h0000;
         wake_time_ff <= 12'h000;
      end else if (apb_wr && slp_ok) begin
         if (a_sleep) begin
            slp_freq_ff <= pwdata[15:0];
            slp_time_ff <= pwdata[27:16];
         end
         if (a_wake) begin
            wake_freq_ff <= pwdata[15:0];
            wake_time_ff <= pwdata[27:16];
         end
      end
   end

   // mode selectors and carrier
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         slp_sel_ff <= SLP_OFF;
         gsel_ff <= GSEL_ONE;
         dir_lock_ff <= DIR_BOTH;
         carrier_ff <= CAR_SLV_MIN;
      end else if (apb_wr && a_mode && mode_ok) begin
         slp_sel_ff <= pwdata[1:0];
         gsel_ff <= pwdata[3:2];
         dir_lock_ff <= pwdata[5:4];
         carrier_ff <= pwdata[12:8];
      end
   end

   // target limits, display scaling, gains, maximum feedback, fallback
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tgt_hi_ff <= TGT_HI_RST;
         tgt_lo_ff <= 7'h00;
         disp_bias_ff <= 16'h0000;
         disp_gain_ff <= 16'h0064;
         gain1_ff <= '0;
         gain2_ff <= '0;
         dec_ff <= 3'h0;
         unit_ff <= 5'h00;
         maxfb_ff <= MAXFB_RST;
         fallbk_ff <= 9'h000;
         di2_fn_ff <= DI_GAIN2_FN;
      end else if (apb_wr) begin
         if (a_tgt && tgt_ok) begin
            tgt_hi_ff <= pwdata[6:0];
            tgt_lo_ff <= pwdata[14:8];
         end
         if (a_disp && disp_ok) begin
            disp_bias_ff <= pwdata[15:0];
            disp_gain_ff <= pwdata[31:16];
         end
         if (a_gain2 && g2_ok) begin
            gain2_ff.prop <= pwdata[9:0];
            gain2_ff.integ <= pwdata[25:16];
         end
         if (a_gain2b && g2b_ok) begin
            gain2_ff.diff <= pwdata[9:0];
            dec_ff <= pwdata[18:16];
            unit_ff <= pwdata[28:24];
         end
         if (a_maxfb && maxfb_ok) maxfb_ff <= pwdata[13:0];
         if (a_fallbk && fb_ok) fallbk_ff <= pwdata[8:0];
         if (a_di2) di2_fn_ff <= pwdata[5:0];
      end
   end

   // read mux
   wire [31:0] rd_status = {24'h0, cfg_rej_ff, conflict_ff, loss_flag_ff, fault_contact,
      2'b00, state_ff};
   wire [31:0] rd_word =
      a_loss ? {9'h0, loss_time_ff, 1'b0, loss_lvl_ff, 6'h0, loss_mode_ff} :
      a_sleep ? {4'h0, slp_time_ff, slp_freq_ff} :
      a_wake ? {4'h0, wake_time_ff, wake_freq_ff} :
      a_mode ? {19'h0, carrier_ff, 2'b00, dir_lock_ff, gsel_ff, slp_sel_ff} :
      a_tgt ? {17'h0, tgt_lo_ff, 1'b0, tgt_hi_ff} :
      a_disp ? {disp_gain_ff, disp_bias_ff} :
      a_gain2 ? {6'h0, gain2_ff.integ, 6'h0, gain2_ff.prop} :
      a_gain2b ? {3'h0, unit_ff, 5'h0, dec_ff, 6'h0, gain2_ff.diff} :
      a_maxfb ? {18'h0, maxfb_ff} :
      a_fallbk ? {23'h0, fallbk_ff} :
      a_di2 ? {26'h0, di2_fn_ff} :
      a_status ? rd_status : 32'h0;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) prdata <= 32'h0;
      else if (apb_rd_sel && !penable) prdata <= rd_word;
   end

   ////////////////////////////////////////////////////////////////////
   // 0.1 s tick
   assign tick = tick_cnt_ff == 24'(TICK_CYC - 1);
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) tick_cnt_ff <= 24'h0;
      else tick_cnt_ff <= tick ? 24'h0 : tick_cnt_ff + 24'h1;
   end

   // source conflict, checked against the live selections
   wire conflict = tgt_src == fb_src; // see RQ7
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         conflict_ff <= 1'b0;
         cfg_rej_ff <= 1'b0;
      end else begin
         conflict_ff <= conflict;
         cfg_rej_ff <= conflict; // feedback loss supervision suspended, see RQ7
      end
   end

   // feedback loss qualification
   wire loss_cond = loss_mode_ff != LOSS_OFF && fb_pct < loss_lvl_ff; // see RQ22
   wire loss_done = loss_cnt_ff >= loss_time_ff;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) loss_cnt_ff <= 7'h0;
      else if (!loss_cond) loss_cnt_ff <= 7'h0; // see RQ23
      else if (tick && !loss_done) loss_cnt_ff <= loss_cnt_ff + 7'h1;
   end
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) loss_flag_ff <= 1'b0;
      else loss_flag_ff <= loss_cond && loss_done && !cfg_rej_ff;
   end
   wire loss_warn = loss_flag_ff && loss_mode_ff == LOSS_WARN; // see RQ21
   wire loss_fault = loss_flag_ff && loss_mode_ff == LOSS_FAULT; // see RQ1

   // sleep enable source
   wire slp_en = (slp_sel_ff == SLP_PARAM) || (slp_sel_ff == SLP_DI && sleep_di); // see RQ4

   // sleep and wake qualification timers
   wire slp_cond = slp_en && state_ff == PIDSUP_RUN && pid_out_freq < slp_freq_ff; // see RQ5
   wire slp_done = slp_cnt_ff >= slp_time_ff;
   wire wake_cond = state_ff == PIDSUP_SLEEP && pid_ref_freq > wake_freq_ff; // see RQ3
   wire wake_done = wake_cnt_ff >= wake_time_ff;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         slp_cnt_ff <= 12'h0;
         wake_cnt_ff <= 12'h0;
      end else begin
         slp_cnt_ff <= !slp_cond ? 12'h0 : (tick && !slp_done) ? slp_cnt_ff + 12'h1 :
            slp_cnt_ff; // see RQ23
         wake_cnt_ff <= !wake_cond ? 12'h0 : (tick && !wake_done) ? wake_cnt_ff + 12'h1 :
            wake_cnt_ff; // see RQ23
      end
   end

   // supervisor state machine
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         PIDSUP_RUN: begin
            if (loss_fault) nxt_state = PIDSUP_FAULT; // see RQ1
            else if (slp_cond && slp_done) nxt_state = PIDSUP_DECEL; // see RQ2
         end
         PIDSUP_DECEL: begin
            if (loss_fault) nxt_state = PIDSUP_FAULT;
            else if (motor_stopped) nxt_state = PIDSUP_SLEEP; // see RQ5
         end
         PIDSUP_SLEEP: begin
            if (loss_fault) nxt_state = PIDSUP_FAULT;
            else if (!slp_en) nxt_state = PIDSUP_RUN;
            else if (wake_cond && wake_done) nxt_state = PIDSUP_RUN; // see RQ6
         end
         PIDSUP_FAULT: begin
            if (loss_mode_ff != LOSS_FAULT) nxt_state = PIDSUP_RUN;
         end
         default: nxt_state = PIDSUP_RUN;
      endcase
   end
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) state_ff <= PIDSUP_RUN;
      else state_ff <= nxt_state;
   end

   // direction lock and run command
   wire fwd_ok = run_fwd && dir_lock_ff != DIR_REV; // see RQ17
   wire rev_ok = run_rev && dir_lock_ff != DIR_FWD; // see RQ17
   wire run_req = (fwd_ok ^ rev_ok) && state_ff == PIDSUP_RUN && !conflict;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         run_cmd_ff <= 1'b0;
         dir_rev_ff <= 1'b0;
      end else begin
         run_cmd_ff <= run_req;
         if (run_req) dir_rev_ff <= rev_ok;
      end
   end
   assign run_cmd = run_cmd_ff;
   assign dir_rev = dir_rev_ff;
   assign fault_contact = state_ff == PIDSUP_FAULT; // see RQ1

   // display code, fault outranks warning outranks conflict
   assign disp_code = state_ff == PIDSUP_FAULT ? DSP_FAULT :
      loss_warn ? DSP_WARN : conflict_ff ? DSP_CONFL : DSP_NONE;

   ////////////////////////////////////////////////////////////////////
   // data outputs
   wire [6:0] tgt_clamp = tgt_pct_in > tgt_hi_ff ? tgt_hi_ff :
      tgt_pct_in < tgt_lo_ff ? tgt_lo_ff : tgt_pct_in; // see RQ9
   wire [15:0] fallbk_hz = 16'(fallbk_ff) * 16'd100;
   wire [15:0] freq_nxt = loss_warn ? fallbk_hz : pid_ref_freq; // see RQ16
   // feedback in units: maxfb * pct / 100 * gain/100 + bias
   wire [20:0] fb_units = 21'((28'(maxfb_ff) * 28'(fb_pct)) / 28'd100); // see RQ13
   wire [31:0] fb_scaled = 32'((37'(fb_units) * 37'(disp_gain_ff)) / 37'd100)
      + 32'($signed(disp_bias_ff)); // see RQ8
   wire gain2_sel = gsel_ff == GSEL_TWO ||
      (gsel_ff == GSEL_DI && gain_di && gain_di_fn == di2_fn_ff); // see RQ10 // see RQ11
   wire [4:0] car_dec = carrier_ff; // see RQ18
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         freq_cmd <= 16'h0;
         tgt_pct <= 7'h0;
         fb_disp <= 16'h0;
         gain_act <= '0;
         carrier_khz <= 5'h0;
         carrier_var <= 1'b0;
         carrier_half <= 1'b0;
      end else begin
         freq_cmd <= state_ff == PIDSUP_RUN ? freq_nxt : 16'h0;
         tgt_pct <= tgt_clamp;
         fb_disp <= fb_scaled[15:0];
         gain_act <= gain2_sel ? gain2_ff : gain1_ff; // see RQ12
         carrier_khz <= car_dec;
         carrier_var <= car_dec == CAR_VAR;
         carrier_half <= car_dec == CAR_1K5;
      end
   end
endmodule : pidsup_top

/* hdl/pidsup_pkg.sv */
// Purpose: shared constants and types for the pid supervisor block
// Assumes: 10 MHz core clock, APB register access, values in 0.01 or 0.1 units
// Notes: register offsets are byte addresses, one aligned word each
package pidsup_pkg;
   // clock and time base
   localparam int CLK_HZ = 10000000;
   localparam int TICK_MS = 100; // timers count in 0.1 s ticks
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   // register offsets
   localparam logic [7:0] OFS_LOSS = 8'h00;
   localparam logic [7:0] OFS_SLEEP = 8'h04;
   localparam logic [7:0] OFS_WAKE = 8'h08;
   localparam logic [7:0] OFS_MODE = 8'h0C;
   localparam logic [7:0] OFS_TGT = 8'h10;
   localparam logic [7:0] OFS_DISP = 8'h14;
   localparam logic [7:0] OFS_GAIN2 = 8'h18;
   localparam logic [7:0] OFS_MAXFB = 8'h1C;
   localparam logic [7:0] OFS_FALLBK = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h24;
   localparam logic [7:0] OFS_DI2 = 8'h28;
   localparam logic [7:0] OFS_GAIN2B = 8'h2C;
   // field encodings
   localparam logic [1:0] LOSS_OFF = 2'h0;
   localparam logic [1:0] LOSS_WARN = 2'h1;
   localparam logic [1:0] LOSS_FAULT = 2'h2;
   localparam logic [1:0] SLP_OFF = 2'h0;
   localparam logic [1:0] SLP_PARAM = 2'h1;
   localparam logic [1:0] SLP_DI = 2'h2;
   localparam logic [1:0] GSEL_ONE = 2'h0;
   localparam logic [1:0] GSEL_TWO = 2'h1;
   localparam logic [1:0] GSEL_DI = 2'h2;
   localparam logic [1:0] DIR_BOTH = 2'h0;
   localparam logic [1:0] DIR_FWD = 2'h1;
   localparam logic [1:0] DIR_REV = 2'h2;
   localparam logic [4:0] CAR_VAR = 5'h00;
   localparam logic [4:0] CAR_1K5 = 5'h01;
   localparam logic [4:0] CAR_MAX = 5'h10;
   localparam logic [4:0] CAR_SLV_MIN = 5'h04;
   localparam logic [5:0] DI_GAIN2_FN = 6'h36; // function code 54
   localparam logic [3:0] DEC_MAX = 4'h4;
   localparam logic [4:0] UNIT_MAX = 5'h17; // 23
   localparam logic [6:0] PCT_MAX = 7'h64; // 100 percent
   localparam logic [13:0] MAXFB_MIN = 14'h0001;
   localparam logic [13:0] MAXFB_MAX = 14'h2710; // 10000
   localparam logic [13:0] MAXFB_RST = 14'h2710;
   localparam logic [6:0] TGT_HI_RST = 7'h64;
   localparam logic [9:0] GAIN_PMAX = 10'h3E8; // 10.00
   localparam logic [9:0] GAIN_IMAX = 10'h3E8; // 100.0 s
   localparam logic [9:0] GAIN_DMAX = 10'h3E8; // 10.00 s
   localparam logic [6:0] LOSS_TMAX = 7'h64; // 10.0 s
   localparam logic [15:0] FREQ_MAX = 16'h4650; // 180.00 Hz
   localparam logic [11:0] SLEEP_TMAX = 12'h9FB; // 255.5 s
   localparam logic [8:0] FALLBK_MAX = 9'h190; // 400 Hz
   // display codes
   localparam logic [2:0] DSP_NONE = 3'h0;
   localparam logic [2:0] DSP_WARN = 3'h1; // feedback_warning_code
   localparam logic [2:0] DSP_FAULT = 3'h2; // feedback_fault_code
   localparam logic [2:0] DSP_CONFL = 3'h3; // source_conflict_alarm
   // supervisor state
   typedef enum logic [1:0] {
      PIDSUP_RUN = 2'b00,
      PIDSUP_DECEL = 2'b01,
      PIDSUP_SLEEP = 2'b10,
      PIDSUP_FAULT = 2'b11
   } pidsup_state_t;
   // gain set carried to the pid arithmetic
   typedef struct packed {
      logic [9:0] prop;
      logic [9:0] integ;
      logic [9:0] diff;
   } pidsup_gain_t;
endpackage : pidsup_pkg

/* verif/pidsup_assertions.sv */
// Purpose: port checks for the pid supervisor
// Assumes: one clock, asynchronous active-low reset
// Notes: bound onto pidsup_top
`timescale 1ns/1ps
module pidsup_assertions
   import pidsup_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [1:0] tgt_src,
   input wire logic [1:0] fb_src,
   input wire logic run_fwd,
   input wire logic run_rev,
   input wire logic run_cmd,
   input wire logic dir_rev,
   input wire logic fault_contact,
   input wire logic [2:0] disp_code,
   input wire logic [6:0] tgt_pct,
   input wire logic [4:0] carrier_khz,
   input wire logic carrier_var,
   input wire logic carrier_half
);
   default clocking dcb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////////
   // access phase and source clash
   sequence apb_acc;
      psel && penable;
   endsequence
   sequence src_clash;
      tgt_src == fb_src;
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   zero_wait_a: assert property (apb_acc |-> pready)
      else $error("access not ready");
   err_phase_a: assert property (pslverr |-> apb_acc)
      else $error("slave error outside access");
   fault_stop_a: assert property (fault_contact |=> !run_cmd)
      else $error("running in fault");
   fault_code_a: assert property (fault_contact |-> disp_code == DSP_FAULT)
      else $error("fault code missing");
   clash_stop_a: assert property (src_clash |=> !run_cmd)
      else $error("running with source clash");
   dir_one_a: assert property (run_cmd |-> (dir_rev ? $past(run_rev) : $past(run_fwd)))
      else $error("run without one direction");
   dir_sense_a: assert property (run_cmd && !$past(run_fwd) |-> dir_rev)
      else $error("direction wrong");
   tgt_range_a: assert property (tgt_pct <= PCT_MAX)
      else $error("target above full scale");
   car_flag_a: assert property (carrier_var || carrier_half |->
      carrier_khz == {4'h0, carrier_half})
      else $error("carrier flag mismatch");
endmodule : pidsup_assertions
bind pidsup_top pidsup_assertions u_chk (.core_clk, .rst_b, .psel, .penable, .pready, .pslverr,
   .tgt_src, .fb_src, .run_fwd, .run_rev, .run_cmd, .dir_rev, .fault_contact, .disp_code,
   .tgt_pct, .carrier_khz, .carrier_var, .carrier_half);

/* verif/pidsup_motor.sv */
// Purpose: motor stand-in for the pid supervisor bench
// Assumes: run_cmd level, one clock
// Notes: coasts STOP_CYC cycles before reporting standstill
`timescale 1ns/1ps
module pidsup_motor #(
   parameter int STOP_CYC = 6
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic run_cmd,
   output logic motor_stopped
);
   logic [7:0] coast_ff;
   logic [7:0] nxt_coast;
   // coast count; short cable keeps every carrier legal
   assign nxt_coast = run_cmd ? 8'h00 : motor_stopped ? coast_ff : coast_ff + 8'h01;
   assign motor_stopped = coast_ff == 8'(STOP_CYC);
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         coast_ff <= 8'h00;
      end else begin
         coast_ff <= nxt_coast;
      end
   end
endmodule : pidsup_motor

/* verif/pidsup_tb.sv */
// Purpose: self-checking bench for the pid supervisor
// Assumes: zero-wait apb, all delay settings zero
// Notes: seeded random requests among corner cases
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
   $display("BAD %s exp %0h got %0h", nm, e, g); end end
module pidsup_tb;
   import pidsup_pkg::*;
   logic core_clk = '0, rst_b = '0, psel = '0, penable = '0, pwrite = '0, er;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [15:0] pid_out_freq = 16'h1388, pid_ref_freq = '0, freq_cmd, fb_disp;
   logic [6:0] fb_pct = 7'h50, tgt_pct_in = '0, tgt_pct;
   logic [1:0] tgt_src = '0, fb_src = 2'h1;
   logic [5:0] gain_di_fn = DI_GAIN2_FN;
   logic sleep_di = '0, gain_di = '0, run_fwd = '0, run_rev = '0, sensorless_vector_mode = '0;
   logic pready, pslverr, motor_stopped, run_cmd, dir_rev, fault_contact, carrier_var;
   logic carrier_half;
   logic [2:0] disp_code;
   logic [4:0] carrier_khz;
   pidsup_gain_t gain_act;
   int err_count = 0, n_compared = 0;
   logic [7:0] t_a [8] = '{OFS_MAXFB, OFS_MAXFB, OFS_GAIN2B, OFS_GAIN2B, OFS_GAIN2B,
      OFS_FALLBK, OFS_FALLBK, OFS_GAIN2};
   logic [31:0] t_d [8] = '{32'h0, 32'h2711, 32'h50000, 32'h170403E8, 32'h180403E8,
      32'h191, 32'h190, 32'h3E803E8};
   logic [31:0] t_e [8] = '{32'h2710, 32'h2710, 32'h0, 32'h170403E8, 32'h170403E8,
      32'h0, 32'h190, 32'h3E803E8};
   logic [4:0] cv [4] = '{CAR_VAR, CAR_1K5, 5'h02, CAR_MAX};
   pidsup_top u_dut (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .pid_out_freq, .pid_ref_freq, .fb_pct, .tgt_src, .fb_src, .tgt_pct_in,
      .sleep_di, .gain_di_fn, .gain_di, .run_fwd, .run_rev, .motor_stopped, .run_cmd,
      .sensorless_vector_mode, .dir_rev, .fault_contact, .disp_code, .freq_cmd, .tgt_pct,
      .fb_disp, .gain_act, .carrier_khz, .carrier_var, .carrier_half);
   pidsup_motor u_motor (.core_clk, .rst_b, .run_cmd, .motor_stopped);
   // 100 ns clock
   always #50 core_clk = ~core_clk;
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic exp_run(input logic [1:0] d, input logic f, input logic r);
      return (f && d != DIR_REV) ^ (r && d != DIR_FWD);
   endfunction : exp_run
   function automatic logic [6:0] clamp(input logic [6:0] v);
      return (v > 7'h46) ? 7'h46 : (v < 7'h14) ? 7'h14 : v;
   endfunction : clamp
   task automatic complete_run;
      if (err_count == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : complete_run
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tick
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge core_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      for (k = 0; k < 20; k++) begin
         @(posedge core_clk);
         if (pready === 1'h1) break;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (k == 20) begin
         err_count++;
         complete_run();
      end
   endtask : apb
   task automatic set_mode(input logic [1:0] s, g, d, input logic [4:0] c);
      apb(1'h1, OFS_MODE, {19'h0, c, 2'h0, d, g, s});
   endtask : set_mode
   task automatic wait_for(input logic w, input logic v);
      int k;
      for (k = 0; k < 60; k++) begin
         @(posedge core_clk);
         if ((w ? motor_stopped : run_cmd) === v) break;
      end
      `CHK("wait", v, w ? motor_stopped : run_cmd)
      if (k == 60) complete_run();
   endtask : wait_for
   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      void'($urandom(10));
      repeat (16) @(posedge core_clk);
      rst_b <= 1'h1;
      apb(1'h0, OFS_TGT, '0);
      `CHK("tgt hi", TGT_HI_RST, rd[6:0])
      apb(1'h0, 8'h30, '0);
      `CHK("unmapped", 2'h2, {er, |rd})
      for (int i = 0; i < 8; i++) begin
         apb(1'h1, t_a[i], t_d[i]);
         apb(1'h0, t_a[i], '0);
         `CHK("readback", t_e[i], rd)
      end
      foreach (cv[i]) begin
         set_mode(SLP_OFF, GSEL_ONE, DIR_BOTH, cv[i]);
         tick(2);
         `CHK("car", {cv[i], i == 0, i == 1}, {carrier_khz, carrier_var, carrier_half})
      end
      sensorless_vector_mode <= 1'h1;
      set_mode(SLP_OFF, GSEL_ONE, DIR_BOTH, 5'h03);
      set_mode(SLP_OFF, GSEL_ONE, DIR_BOTH, 5'h11);
      tick(2);
      `CHK("slv car", CAR_MAX, carrier_khz)
      sensorless_vector_mode <= 1'h0;
      for (int i = 0; i < 4; i++) begin
         gain_di <= i[0];
         set_mode(SLP_OFF, (i > 1) ? GSEL_DI : 2'(i), DIR_BOTH, CAR_SLV_MIN);
         tick(3);
         `CHK("gain", i[0] ? 30'h3E8FA3E8 : 30'h0, gain_act)
      end
      for (int i = 0; i < 24; i++) begin
         if (i % 8 == 0) set_mode(SLP_OFF, GSEL_ONE, 2'(2 - i / 8), CAR_SLV_MIN);
         run_fwd <= 1'($urandom);
         run_rev <= 1'($urandom);
         tick(3);
         `CHK("run", exp_run(2'(2 - i / 8), run_fwd, run_rev), run_cmd)
      end
      apb(1'h1, OFS_TGT, 32'h1446);
      apb(1'h1, OFS_TGT, 32'h501E);
      for (int i = 0; i < 8; i++) begin
         tgt_pct_in <= (i == 0) ? PCT_MAX : 7'($urandom_range(100));
         tick(3);
         `CHK("target", clamp(tgt_pct_in), tgt_pct)
      end
      run_fwd <= 1'h1;
      run_rev <= 1'h0;
      fb_pct <= 7'h32;
      apb(1'h1, OFS_LOSS, 32'h3201);
      tick(4);
      `CHK("at level", DSP_NONE, disp_code)
      fb_pct <= 7'h31;
      tick(4);
      `CHK("warn", {DSP_WARN, 1'h1, 16'h9C40}, {disp_code, run_cmd, freq_cmd})
      fb_pct <= 7'h50;
      tick(4);
      `CHK("warn off", DSP_NONE, disp_code)
      apb(1'h1, OFS_LOSS, 32'h3202);
      fb_pct <= 7'h00;
      tick(4);
      `CHK("fault", {DSP_FAULT, 2'h2}, {disp_code, fault_contact, run_cmd})
      apb(1'h1, OFS_LOSS, '0);
      fb_pct <= 7'h50;
      fb_src <= 2'h0;
      tick(3);
      `CHK("clash", {DSP_CONFL, 1'h0, 16'h1F40}, {disp_code, run_cmd, fb_disp})
      fb_src <= 2'h1;
      apb(1'h1, OFS_SLEEP, 32'h3E8);
      apb(1'h1, OFS_WAKE, 32'h7D0);
      for (int i = 0; i < 4; i++) begin
         sleep_di <= (i == 0 || i == 3);
         set_mode((i > 1) ? SLP_DI : 2'(i), GSEL_ONE, DIR_BOTH, CAR_SLV_MIN);
         pid_out_freq <= 16'h01F4;
         tick(4);
         `CHK("sleep", !i[0], run_cmd)
         if (i[0]) begin
            wait_for(1'h1, 1'h1);
            pid_ref_freq <= 16'h07D0;
            tick(4);
            `CHK("no wake", 1'h0, run_cmd)
            pid_out_freq <= 16'h1388;
            pid_ref_freq <= 16'h0BB8;
            wait_for(1'h0, 1'h1);
         end
         pid_out_freq <= 16'h1388;
      end
      complete_run();
   end
endmodule : pidsup_tb
